// file: ocfd_cfg.svh
// Constants for the oscillator configuration fuse decoder: map, fields, codes.
`ifndef OCFD_CFG_SVH
`define OCFD_CFG_SVH

// Fuse array shape.
`define OCFD_WORD_COUNT 7
`define OCFD_WORD_W 16
`define OCFD_IDX_W 3
`define OCFD_ERASED 16'hFFFF

// Word indices read during the power-on load.
`define OCFD_OSC_IDX 3'h0
`define OCFD_CP_IDX 3'h6

// Byte addresses of the extra registers; fuse word n sits at 4*n.
`define OCFD_STATUS_ADDR 8'h1C
`define OCFD_CTRL_ADDR 8'h20

// Control register fields.
`define OCFD_CTRL_IDX_MSB 2
`define OCFD_CTRL_IDX_LSB 0
`define OCFD_CTRL_GO_BIT 8

// Oscillator word fields.
`define OCFD_PMODE_MSB 3
`define OCFD_PMODE_LSB 0
`define OCFD_SRC_MSB 9
`define OCFD_SRC_LSB 8
`define OCFD_SWMON_MSB 15
`define OCFD_SWMON_LSB 14

// Power-on source code for the internal low-power RC oscillator.
`define OCFD_SRC_LPRC 2'h2

// Code-protect bit in its word; a programmed (zero) bit protects.
`define OCFD_CP_BIT 0
`define OCFD_CP_ON 1'h0

// Clock switch and monitor codes.
`define OCFD_SWMON_SW_ONLY 2'h1
`define OCFD_SWMON_BOTH 2'h0

// Primary oscillator mode codes.
`define OCFD_PMODE_EXTIO_X16 4'hF
`define OCFD_PMODE_EXTIO_X8 4'hE
`define OCFD_PMODE_EXTIO_X4 4'hD
`define OCFD_PMODE_EXTIO 4'hC
`define OCFD_PMODE_EXTCLK_OUT 4'hB
`define OCFD_PMODE_RESERVED 4'hA
`define OCFD_PMODE_RC_OUT 4'h9
`define OCFD_PMODE_RC_IO 4'h8
`define OCFD_PMODE_MED_X16 4'h7
`define OCFD_PMODE_MED_X8 4'h6
`define OCFD_PMODE_MED_X4 4'h5
`define OCFD_PMODE_MED 4'h4
`define OCFD_PMODE_FAST_XTAL_TOP 3'h1
`define OCFD_PMODE_SLOW_XTAL_TOP 3'h0

`endif

// file: ocfd_pkg.sv
// Types shared by the oscillator configuration fuse decoder.
package ocfd_pkg;

	// Power-on oscillator source, encoded as the fuse field.
	typedef enum logic [1:0] {
		SRC_LP_32K = 2'h0,
		SRC_FAST_RC = 2'h1,
		SRC_LOW_POWER_RC = 2'h2,
		SRC_PRIMARY = 2'h3
	} ocfd_osc_source_type;

	// Primary oscillator mode after decoding.
	typedef enum logic [2:0] {
		PM_EXT_CLOCK_PIN_IO = 3'h0,
		PM_EXT_CLOCK_WITH_OUTPUT = 3'h1,
		PM_EXT_RC_WITH_OUTPUT = 3'h2,
		PM_EXT_RC_PIN_IO = 3'h3,
		PM_MEDIUM_CRYSTAL = 3'h4,
		PM_HIGH_SPEED_CRYSTAL = 3'h5,
		PM_LOW_FREQ_CRYSTAL = 3'h6,
		PM_RESERVED = 3'h7
	} ocfd_pri_mode_type;

	// PLL multiplier in front of the primary oscillator.
	typedef enum logic [1:0] {
		PLL_NONE = 2'h0,
		PLL_X4 = 2'h1,
		PLL_X8 = 2'h2,
		PLL_X16 = 2'h3
	} ocfd_pll_type;

	// Load sequencer states, one-hot.
	typedef enum logic [3:0] {
		ST_RD_OSC = 4'h1,
		ST_CAP_OSC = 4'h2,
		ST_CAP_CP = 4'h4,
		ST_RUN = 4'h8
	} ocfd_state_type;

endpackage

// file: ocfd_fuse_mem.sv
// Small array holding the nonvolatile configuration words, with registered read.
`timescale 1ns/10ps

module ocfd_fuse_mem
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 7,
	parameter int AW = 3
)
(
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Write port.
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	// Read port.
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);

	// The cells model nonvolatile storage, so reset does not touch them.
	logic [WIDTH-1:0] cells [DEPTH];

	// Read index inside the array; outside it reads as zero.
	wire rd_in_range = (int'(raddr) < DEPTH);

	// Write port; the caller keeps waddr inside the array.
	always_ff @(posedge clk)
	begin
		if (ce && we)
			cells[waddr] <= wdata;
	end

	// Read data come out of a register one cycle after the address.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= '0;
		else if (ce)
			rdata <= rd_in_range ? cells[raddr] : '0;
	end

endmodule

// file: ocfd_decode.sv
// Oscillator configuration fuse decoder with APB access to the fuse words.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps
`include "ocfd_cfg.svh"
// Notes on behaviour
// - Seven sixteen-bit fuse words hold configuration.
// - System bits set clock settings at power-up.
// - Active code protect blocks program memory access.
// - Switch field: 1x none, 01 switch, 00 both.
// - Source field picks primary, LPRC, FRC, 32k.
// - Codes 1111-1100 external clock, pin I/O, PLL.
// - 1011, 1001 output clock/4; 1000 RC I/O.
// - 0111-0100 medium crystal, x16/x8/x4/no PLL.
// - 001x high-speed, 000x low-frequency crystal.

module ocfd_decode
	import ocfd_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// Clock, reset and clock enable.
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// APB slave.
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Decoded clock settings.
	output logic cfg_valid,
	output logic clk_switch_en,
	output logic fail_safe_mon_en,
	output ocfd_osc_source_type osc_source,
	output ocfd_pri_mode_type primary_osc_mode,
	output ocfd_pll_type pll_mult,
	output logic secondary_osc_pin_io,
	output logic secondary_osc_pin_clkout,
	// Program memory access gate.
	input wire logic pmem_rd_req,
	input wire logic pmem_wr_req,
	output logic pmem_rd_grant,
	output logic pmem_wr_grant,
	output logic code_protect_active
);

	// Maps a primary mode code to its oscillator kind.
	function automatic ocfd_pri_mode_type pri_mode_of(input logic [3:0] code);
		ocfd_pri_mode_type m;
		m = PM_RESERVED;
		case (code)
			`OCFD_PMODE_EXTIO_X16, `OCFD_PMODE_EXTIO_X8,
			`OCFD_PMODE_EXTIO_X4, `OCFD_PMODE_EXTIO:
				m = PM_EXT_CLOCK_PIN_IO;
			`OCFD_PMODE_EXTCLK_OUT: m = PM_EXT_CLOCK_WITH_OUTPUT;
			`OCFD_PMODE_RC_OUT: m = PM_EXT_RC_WITH_OUTPUT;
			`OCFD_PMODE_RC_IO: m = PM_EXT_RC_PIN_IO;
			`OCFD_PMODE_MED_X16, `OCFD_PMODE_MED_X8,
			`OCFD_PMODE_MED_X4, `OCFD_PMODE_MED:
				m = PM_MEDIUM_CRYSTAL;
			default:
			begin
				// The bottom bit is a don't-care for the two remaining crystals.
				if (code[3:1] == `OCFD_PMODE_FAST_XTAL_TOP)
					m = PM_HIGH_SPEED_CRYSTAL;
				else if (code[3:1] == `OCFD_PMODE_SLOW_XTAL_TOP)
					m = PM_LOW_FREQ_CRYSTAL;
				else
					m = PM_RESERVED;
			end
		endcase
		return m;
	endfunction

	// Maps a primary mode code to its PLL multiplier.
	function automatic ocfd_pll_type pll_of(input logic [3:0] code);
		ocfd_pll_type p;
		p = PLL_NONE;
		case (code)
			`OCFD_PMODE_EXTIO_X16, `OCFD_PMODE_MED_X16: p = PLL_X16;
			`OCFD_PMODE_EXTIO_X8, `OCFD_PMODE_MED_X8: p = PLL_X8;
			`OCFD_PMODE_EXTIO_X4, `OCFD_PMODE_MED_X4: p = PLL_X4;
			default: p = PLL_NONE;
		endcase
		return p;
	endfunction

	// Synchronised reset; the clock enable does not gate it so release is never stuck.
	logic rst_s1;
	logic rst_q;

	// Load sequencer state.
	ocfd_state_type state;
	ocfd_state_type next_state;

	// Captured oscillator word, held from the load until the next reset.
	logic [`OCFD_WORD_W-1:0] osc_word_q;

	// Array read data and write controls.
	logic [`OCFD_WORD_W-1:0] mem_rdata;
	logic [`OCFD_WORD_COUNT-1:0] erase_pend;

	// APB answer state.
	logic ack_q;
	logic err_q;
	logic rd_ready_q;

	// Register decode, all from the held address.
	wire in_run = (state == ST_RUN);
	wire [ADDR_W-3:0] word_idx = paddr[ADDR_W-1:2];
	wire [`OCFD_IDX_W-1:0] word_sel = paddr[`OCFD_IDX_W+1:2];
	wire aligned = (paddr[1:0] == 2'h0);
	wire fuse_hit = aligned && (int'(word_idx) < `OCFD_WORD_COUNT);
	wire status_hit = (paddr == ADDR_W'(`OCFD_STATUS_ADDR));
	wire ctrl_hit = (paddr == ADDR_W'(`OCFD_CTRL_ADDR));
	wire bad_access = !(fuse_hit || status_hit || ctrl_hit) || (pwrite && status_hit);

	// A transfer completes at the edge where the access phase sees pready.
	wire access = psel && penable && in_run;
	wire wr_fire = access && ack_q && pwrite && !err_q;
	wire [`OCFD_IDX_W-1:0] erase_idx = pwdata[`OCFD_CTRL_IDX_MSB:`OCFD_CTRL_IDX_LSB];
	wire fuse_we = wr_fire && fuse_hit;
	wire erase_we = wr_fire && ctrl_hit && pwdata[`OCFD_CTRL_GO_BIT]
		&& (int'(erase_idx) < `OCFD_WORD_COUNT);

	// One array port serves both the load and the bus.
	wire mem_we = fuse_we || erase_we;
	wire [`OCFD_IDX_W-1:0] mem_waddr = fuse_we ? word_sel : erase_idx;
	wire [`OCFD_WORD_W-1:0] mem_wdata = fuse_we ? pwdata[`OCFD_WORD_W-1:0] : `OCFD_ERASED;
	wire [`OCFD_IDX_W-1:0] mem_raddr = (state == ST_RD_OSC) ? `OCFD_OSC_IDX :
		(state == ST_CAP_OSC) ? `OCFD_CP_IDX : word_sel;

	// Fields of the captured oscillator word.
	wire [1:0] swmon_field = osc_word_q[`OCFD_SWMON_MSB:`OCFD_SWMON_LSB];
	wire [1:0] src_field = osc_word_q[`OCFD_SRC_MSB:`OCFD_SRC_LSB];
	wire [3:0] pmode_field = osc_word_q[`OCFD_PMODE_MSB:`OCFD_PMODE_LSB];
	wire ocfd_pri_mode_type dec_mode = pri_mode_of(pmode_field);
	wire ocfd_pll_type dec_pll = pll_of(pmode_field);

	// Status view of the block's own state.
	wire [31:0] status_word = {9'h000, erase_pend, 3'h0, cfg_valid, code_protect_active,
		secondary_osc_pin_io, secondary_osc_pin_clkout, fail_safe_mon_en, clk_switch_en,
		pll_mult, primary_osc_mode, osc_source};
	wire [31:0] rd_mux = fuse_hit ? {16'h0000, mem_rdata} : status_hit ? status_word : 32'h00000000;

	// The array of seven fuse words.
	ocfd_fuse_mem #(
		.WIDTH(`OCFD_WORD_W),
		.DEPTH(`OCFD_WORD_COUNT),
		.AW(`OCFD_IDX_W)
	) u_mem (
		.clk(clk),
		.rst_n(rst_q),
		.ce(ce),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// Reset release through two flip-flops.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_s1 <= 1'b0;
			rst_q <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_q <= rst_s1;
		end
	end

	// Load walk: read the oscillator word, then the protect word, then run.
	always_comb
	begin
		case (state)
			ST_RD_OSC: next_state = ST_CAP_OSC;
			ST_CAP_OSC: next_state = ST_CAP_CP;
			ST_CAP_CP: next_state = ST_RUN;
			ST_RUN: next_state = ST_RUN;
			default: next_state = ST_RD_OSC;
		endcase
	end

	// Sequencer register; only a reset restarts the load.
	always_ff @(posedge clk or negedge rst_q)
	begin
		if (!rst_q)
			state <= ST_RD_OSC;
		else if (ce)
			state <= next_state;
	end

	// Capture of the power-on settings. Later fuse writes wait for the next reset.
	always_ff @(posedge clk or negedge rst_q)
	begin
		if (!rst_q)
		begin
			osc_word_q <= '0;
			code_protect_active <= 1'b1;
			cfg_valid <= 1'b0;
			clk_switch_en <= 1'b0;
			fail_safe_mon_en <= 1'b0;
			osc_source <= SRC_FAST_RC;
			primary_osc_mode <= PM_RESERVED;
			pll_mult <= PLL_NONE;
			secondary_osc_pin_io <= 1'b0;
			secondary_osc_pin_clkout <= 1'b0;
		end
		else if (ce && state == ST_CAP_OSC)
			osc_word_q <= mem_rdata;
		else if (ce && state == ST_CAP_CP)
		begin
			code_protect_active <= (mem_rdata[`OCFD_CP_BIT] == `OCFD_CP_ON);
			cfg_valid <= 1'b1;
			clk_switch_en <= !swmon_field[1];
			fail_safe_mon_en <= (swmon_field == `OCFD_SWMON_BOTH);
			osc_source <= ocfd_osc_source_type'(src_field);
			primary_osc_mode <= dec_mode;
			pll_mult <= dec_pll;
			secondary_osc_pin_io <= (dec_mode == PM_EXT_CLOCK_PIN_IO)
				|| (dec_mode == PM_EXT_RC_PIN_IO);
			secondary_osc_pin_clkout <= (dec_mode == PM_EXT_CLOCK_WITH_OUTPUT)
				|| (dec_mode == PM_EXT_RC_WITH_OUTPUT);
		end
	end

	// Erase-pending flags: set by an erase, cleared by the following word write.
	genvar gi;
	generate
		for (gi = 0; gi < `OCFD_WORD_COUNT; gi++)
		begin : g_pend
			wire set_p = erase_we && (int'(erase_idx) == gi);
			wire clr_p = fuse_we && (int'(word_sel) == gi);
			always_ff @(posedge clk or negedge rst_q)
			begin
				if (!rst_q)
					erase_pend[gi] <= 1'b0;
				else if (ce && set_p)
					erase_pend[gi] <= 1'b1;
				else if (ce && clr_p)
					erase_pend[gi] <= 1'b0;
			end
		end
	endgenerate

	// APB answer: the array needs one cycle after the address, so pready comes on
	// the second access cycle; a transfer held over the load waits for run.
	always_ff @(posedge clk or negedge rst_q)
	begin
		if (!rst_q)
		begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rd_ready_q <= 1'b0;
			prdata <= '0;
		end
		else if (ce)
		begin
			rd_ready_q <= in_run && psel;
			ack_q <= access && rd_ready_q && !ack_q;
			if (access && rd_ready_q && !ack_q)
			begin
				err_q <= bad_access;
				prdata <= bad_access ? 32'h00000000 : rd_mux;
			end
		end
	end

	// Handshake outputs.
	assign pready = ack_q;
	assign pslverr = ack_q && err_q;

	// Program memory is shut off while protection is active.
	assign pmem_rd_grant = pmem_rd_req && !code_protect_active;
	assign pmem_wr_grant = pmem_wr_req && !code_protect_active;

	// Assertions.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_q);

	a_protect_block: assert property (code_protect_active |-> !pmem_rd_grant && !pmem_wr_grant)
		else $error("program memory granted while protected");
	a_settings_hold: assert property (cfg_valid |=> $stable(osc_source) && $stable(pll_mult)
		&& $stable(primary_osc_mode) && $stable(clk_switch_en) && cfg_valid)
		else $error("decoded settings changed after load");
	a_load_walk: assert property ((state == ST_RD_OSC) && ce ##1 ce ##1 ce |=> cfg_valid)
		else $error("settings not loaded three enabled cycles after reset");
	a_switch_decode: assert property (cfg_valid |-> (clk_switch_en == !swmon_field[1])
		&& (fail_safe_mon_en == (swmon_field == `OCFD_SWMON_BOTH))
		&& (!fail_safe_mon_en || clk_switch_en))
		else $error("clock switch field decoded wrongly");
	a_source_decode: assert property (cfg_valid && src_field == `OCFD_SRC_LPRC
		|-> osc_source == SRC_LOW_POWER_RC)
		else $error("low-power RC source not selected");
	a_ext_pll_pin: assert property (cfg_valid && pmode_field == `OCFD_PMODE_EXTIO_X4
		|-> pll_mult == PLL_X4 && primary_osc_mode == PM_EXT_CLOCK_PIN_IO
		&& secondary_osc_pin_io)
		else $error("external clock x4 mode decoded wrongly");
	a_clkout_mode: assert property (cfg_valid && (pmode_field == `OCFD_PMODE_EXTCLK_OUT
		|| pmode_field == `OCFD_PMODE_RC_OUT)
		|-> secondary_osc_pin_clkout && !secondary_osc_pin_io && pll_mult == PLL_NONE)
		else $error("clock output modes decoded wrongly");
	a_medium_x16: assert property (cfg_valid && pmode_field == `OCFD_PMODE_MED_X16
		|-> pll_mult == PLL_X16 && primary_osc_mode == PM_MEDIUM_CRYSTAL
		&& !secondary_osc_pin_clkout)
		else $error("medium crystal x16 decoded wrongly");
	a_crystal_lsb: assert property (cfg_valid && pmode_field[3:1] == `OCFD_PMODE_FAST_XTAL_TOP
		|-> primary_osc_mode == PM_HIGH_SPEED_CRYSTAL && pll_mult == PLL_NONE)
		else $error("high-speed crystal decoded wrongly");
	a_write_lands: assert property (fuse_we |=> ##1 !erase_pend[$past(word_sel, 2)])
		else $error("fuse write did not clear erase mark");

endmodule

// file: ocfd_prog_model.sv
// Behavioural model of the external programmer that writes fuse words over APB.
`timescale 1ns/10ps
`include "ocfd_cfg.svh"

module ocfd_prog_model
(
	// Clock.
	input wire logic clk,
	// APB master side.
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr
);
	// The bus idles deselected from time zero.
	initial
	begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end

	// One transfer; the request holds until pready is sampled high at an edge.
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdat,
		output logic [31:0] rdat, output logic err);
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdat;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1)
			@(posedge clk);
		rdat = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// Erase, then write the wanted value even when it equals the erased one; a reserved mode for the oscillator word is skipped.
	task automatic program_word(input logic [2:0] idx, input logic [15:0] val);
		logic [31:0] rd;
		logic err;
		// A real programmer never stores the reserved primary mode in the oscillator word.
		if (idx == `OCFD_OSC_IDX && val[3:0] == `OCFD_PMODE_RESERVED)
			return;
		xfer(1'h1, `OCFD_CTRL_ADDR, {23'h0, 1'h1, 5'h0, idx}, rd, err);
		xfer(1'h1, {3'h0, idx, 2'h0}, {16'h0, val}, rd, err);
	endtask
endmodule

// file: ocfd_decode_tb.sv
// Self-checking testbench for the oscillator configuration fuse decoder.
`timescale 1ns/10ps

module ocfd_decode_tb;
	// Clock, reset and design connections.
	logic clk, rst_b, ce, psel, penable, pwrite, pready, pslverr, cfg_valid;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat, prev;
	logic clk_switch_en, fail_safe_mon_en, pin_io, pin_clkout;
	logic [1:0] osc_source, pll_mult;
	logic [2:0] primary_osc_mode;
	logic rd_req, wr_req, rd_grant, wr_grant, code_protect_active, err, p;
	logic [15:0] w;
	int bad_count, samples_checked;
	// Decoded outputs gathered into one word, laid out like the model's result.
	wire [31:0] seen_cfg = {21'h0, clk_switch_en, fail_safe_mon_en, osc_source,
		primary_osc_mode, pll_mult, pin_io, pin_clkout};

	ocfd_decode ocfd_decode_inst (.clk(clk), .rst_b(rst_b), .ce(ce), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .cfg_valid(cfg_valid),
		.clk_switch_en(clk_switch_en), .fail_safe_mon_en(fail_safe_mon_en),
		.osc_source(osc_source), .primary_osc_mode(primary_osc_mode), .pll_mult(pll_mult),
		.secondary_osc_pin_io(pin_io), .secondary_osc_pin_clkout(pin_clkout),
		.pmem_rd_req(rd_req), .pmem_wr_req(wr_req), .pmem_rd_grant(rd_grant),
		.pmem_wr_grant(wr_grant), .code_protect_active(code_protect_active));

	ocfd_prog_model ocfd_prog_model_inst (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr));

	// Reference decode of an oscillator word, written from the field tables.
	function automatic logic [31:0] model(input logic [15:0] v);
		int f;
		logic [2:0] m;
		logic [1:0] pl;
		f = v[3:0];
		m = 3'(f == 10 ? 7 : f >= 12 ? 0 : f == 11 ? 1 : f == 9 ? 2 : f == 8 ? 3 : f >= 4 ? 4 :
			f >= 2 ? 5 : 6);
		pl = f >= 12 ? 2'(f - 12) : (f >= 4 && f <= 7) ? 2'(f - 4) : 2'h0;
		return {21'h0, ~v[15], v[15:14] == 2'h0, v[9:8], m, pl, f >= 12 || f == 8,
			f == 11 || f == 9};
	endfunction

	// Compares one value; case inequality so an unknown never matches.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Waits, within a bound, for the power-on load to finish.
	task automatic wait_valid();
		for (int n = 0; n < 30 && cfg_valid !== 1'h1; n++)
		begin
			@(posedge clk);
			#1;
		end
		check(cfg_valid, 1);
	endtask

	// Free-running 50 MHz clock.
	initial
	begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	// Watchdog; the whole run needs only a few hundred cycles.
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		stop_test();
	end

	// Main sequence: erase handling, refusals, then every mode code except the reserved one through a reset.
	initial
	begin
		rst_b = 1'h0;
		ce = 1'h1;
		rd_req = 1'h0;
		wr_req = 1'h0;
		bad_count = 0;
		samples_checked = 0;
		prev = 32'h0;
		void'($urandom(3));
		repeat (5) @(posedge clk);
		rst_b <= 1'h1;
		wait_valid();
		// An erase leaves the word blank and pending until the follow-up write.
		ocfd_prog_model_inst.xfer(1, 8'h20, 32'h00000103, rdat, err);
		ocfd_prog_model_inst.xfer(0, 8'h1C, 32'h0, rdat, err);
		check(rdat[19], 1);
		ocfd_prog_model_inst.xfer(0, 8'h0C, 32'h0, rdat, err);
		check(rdat, 32'h0000FFFF);
		ocfd_prog_model_inst.xfer(1, 8'h0C, 32'hFFFFFFFF, rdat, err);
		ocfd_prog_model_inst.xfer(0, 8'h1C, 32'h0, rdat, err);
		check(rdat[19], 0);
		// Unmapped, unaligned and read-only places are refused.
		ocfd_prog_model_inst.xfer(0, 8'h24, 32'h0, rdat, err);
		check(err, 1);
		check(rdat, 0);
		ocfd_prog_model_inst.xfer(0, 8'h02, 32'h0, rdat, err);
		check(err, 1);
		ocfd_prog_model_inst.xfer(1, 8'h1C, 32'h0, rdat, err);
		check(err, 1);
		for (int i = 0; i < 16; i++)
		begin
			if (i == 10)
				continue;
			w = {2'(i), 4'($urandom), 2'(i >> 2), 4'($urandom), 4'(i)};
			p = 1'($urandom);
			ocfd_prog_model_inst.program_word(3'h0, w);
			ocfd_prog_model_inst.program_word(3'h6, {15'($urandom), p});
			ocfd_prog_model_inst.xfer(0, 8'h00, 32'h0, rdat, err);
			check(rdat, {16'h0, w});
			#1;
			if (i > 0)
				check(seen_cfg, prev);
			rst_b <= 1'h0;
			@(posedge clk);
			@(posedge clk);
			rst_b <= 1'h1;
			if (i == 5)
			begin
				// With the enable low the load must stay frozen after reset release.
				ce <= 1'h0;
				repeat (8) @(posedge clk);
				check(cfg_valid, 0);
				ce <= 1'h1;
			end
			wait_valid();
			prev = model(w);
			check(seen_cfg, prev);
			@(posedge clk);
			rd_req <= 1'h1;
			wr_req <= 1'h1;
			@(posedge clk);
			#1;
			check({rd_grant, wr_grant, code_protect_active}, {p, p, ~p});
			@(posedge clk);
			rd_req <= 1'h0;
			wr_req <= 1'h0;
		end
		stop_test();
	end
endmodule
